// [cpu_core_model.sv]
// Behavioural processor core facing the interrupt unit
`timescale 1ns/1ps
module cpu_core_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control from the bench
    input wire logic mask_request,
    // Vector request from the unit
    input wire logic vector_valid,
    input wire logic [15:0] vector_address,
    // Core state
    output logic cpu_int_mask,
    output logic [15:0] last_vector
);
    // Mask bit comes up set, as a core does out of reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_int_mask <= 1'b1;
            last_vector <= 16'h0000;
        end
        else
        begin
            // Software masks before any forcing test is started
            cpu_int_mask <= mask_request;
            if (vector_valid)
            begin
                last_vector <= vector_address;
            end
        end
    end
endmodule : cpu_core_model

// [forced_test_group.sv]
// One group of eight forcing bits
`timescale 1ns/1ps
module forced_test_group #(
    parameter logic [7:0] USABLE = 8'hFF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write port
    input wire logic write_enable,
    input wire logic [7:0] write_data,
    // Forcing bits
    output logic [7:0] forced_bits
);
    typedef struct packed {
        logic [7:0] bits;
    } state_type;

    state_type q;
    state_type d;

    always_comb
    begin
        d = q;
        if (write_enable)
        begin
            d.bits = write_data & USABLE;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign forced_bits = q.bits;
endmodule : forced_test_group

// [interrupt_priority_test_unit.sv]
// Interrupt priority decoder, promotion and test registers, AXI4-Lite
`timescale 1ns/1ps
module interrupt_priority_test_unit (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // System state
    input wire logic special_mode,
    input wire logic cpu_int_mask,
    input wire logic low_power,
    // Requests
    input wire logic [iptu_pkg::REQ_W-1:0] int_req,
    input wire logic nonmaskable_external_request,
    input wire logic por_req,
    input wire logic clock_monitor_req,
    input wire logic watchdog_supervisor_req,
    // Results
    output logic vector_valid,
    output logic [15:0] vector_address,
    output logic wakeup,
    output logic irq
);
    typedef struct packed {
        logic aw_got, w_got, wlane, awready, wready, bvalid;
        logic arready, rvalid, irq, vec_valid;
        logic [7:0] waddr, wbyte, promote;
        logic [1:0] bresp, rresp;
        logic [31:0] rdata;
        logic [4:0] test_control_register;
        logic [iptu_pkg::EV_W-1:0] status, mask;
        logic [15:0] vec;
    } state_type;

    state_type q;
    state_type d;

    logic [iptu_pkg::REQ_W-1:0] forced, ext, eff;
    logic [iptu_pkg::NUM_GROUPS-1:0] grp_we;
    logic [iptu_pkg::MASKABLE_W-1:0] valid_m, ranked;
    logic [iptu_pkg::GRP_W-1:0] sel;
    logic [iptu_pkg::IDX_W-1:0] p_idx, pick_idx;
    logic pick_found, force_active, test_we, do_write, wr_test;
    logic [7:0] promote_eff;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;
    logic [iptu_pkg::EV_W-1:0] ev;

    assign sel = q.test_control_register[iptu_pkg::GRP_W-1:0];
    assign test_we = q.test_control_register[iptu_pkg::TC_WE_BIT];
    // Test stimulus replaces the pins only with interrupts masked
    assign force_active = special_mode & test_we & cpu_int_mask;
    assign do_write = q.aw_got & q.w_got & ~q.bvalid;
    assign wr_test = do_write & q.wlane & special_mode & test_we
        & (q.waddr == iptu_pkg::OFF_FORCED_TEST)
        & (32'(sel) < iptu_pkg::NUM_GROUPS);

    // Group storage; the last group keeps only its low three bits
    for (genvar g = 0; g < iptu_pkg::NUM_GROUPS; g++)
    begin : g_grp
        assign grp_we[g] = wr_test & (sel == iptu_pkg::GRP_W'(g));
        forced_test_group #(
            .USABLE(g == 15 ? iptu_pkg::LAST_GROUP_MASK
                : iptu_pkg::FULL_GROUP_MASK)
        ) u_grp (
            .aclk(aclk),
            .aresetn(aresetn),
            .write_enable(grp_we[g]),
            .write_data(q.wbyte),
            .forced_bits(forced[g*8 +: 8])
        );
    end

    always_comb
    begin
        ext = int_req;
        ext[iptu_pkg::NONMASKABLE_EXTERNAL_REQUEST_IDX] = nonmaskable_external_request;
        eff = force_active ? forced : ext;
    end

    // Decoder ignores the mask bit under test so forced ranking is visible
    assign valid_m = eff[iptu_pkg::MASKABLE_W-1:0]
        & {iptu_pkg::MASKABLE_W{force_active | ~cpu_int_mask}};
    assign promote_eff = q.promote;
    assign p_idx = promote_eff[7:1];

    always_comb
    begin
        ranked = valid_m;
        if (p_idx != iptu_pkg::RTI_IDX)
        begin
            ranked[p_idx] = valid_m[iptu_pkg::RTI_IDX];
            ranked[iptu_pkg::RTI_IDX] = 1'b0;
        end
    end

    priority_pick #(
        .WIDTH(iptu_pkg::MASKABLE_W),
        .IDX_W(iptu_pkg::IDX_W)
    ) u_pick (
        .req(ranked),
        .found(pick_found),
        .index(pick_idx)
    );

    // Wake-up bypasses the clock, which may be stopped in low power
    assign wakeup = low_power
        & ((|valid_m) | nonmaskable_external_request);

    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_resp = iptu_pkg::RESP_OKAY;
        if (araddr == iptu_pkg::OFF_PROMOTE)
            rd_word[7:1] = q.promote[7:1];
        else if (araddr == iptu_pkg::OFF_TEST_CTRL)
        begin
            if (special_mode)
                rd_word[4:0] = q.test_control_register;
        end
        else if (araddr == iptu_pkg::OFF_FORCED_TEST)
        begin
            if (special_mode && 32'(sel) < iptu_pkg::NUM_GROUPS)
            begin
                rd_word[7:0] = eff[sel*8 +: 8];
                if (sel == iptu_pkg::LAST_GROUP)
                    rd_word[7:0] = rd_word[7:0]
                        & iptu_pkg::LAST_GROUP_MASK;
            end
        end
        else if (araddr == iptu_pkg::OFF_STATUS)
            rd_word[iptu_pkg::EV_W-1:0] = q.status;
        else if (araddr == iptu_pkg::OFF_MASK)
            rd_word[iptu_pkg::EV_W-1:0] = q.mask;
        else if (araddr == iptu_pkg::OFF_VECTOR)
            rd_word[16:0] = {q.vec_valid, q.vec};
        else
            rd_resp = iptu_pkg::RESP_SLVERR;
    end

    always_comb
    begin
        d = q;
        ev = '0;
        if (awvalid && q.awready)
        begin
            d.aw_got = 1'b1;
            d.waddr = awaddr;
        end
        if (wvalid && q.wready)
        begin
            d.w_got = 1'b1;
            d.wbyte = wdata[7:0];
            d.wlane = wstrb[0];
        end
        if (q.bvalid && bready)
        begin
            d.bvalid = 1'b0;
        end
        if (do_write)
        begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = iptu_pkg::RESP_OKAY;
            if (q.waddr == iptu_pkg::OFF_PROMOTE)
            begin
                if (q.wlane && cpu_int_mask)
                begin
                    if (q.wbyte > iptu_pkg::PROMOTE_LIMIT)
                        d.promote = iptu_pkg::PROMOTE_RESET;
                    else
                        d.promote = {q.wbyte[7:1], 1'b0};
                end
                else
                    ev[iptu_pkg::EV_PROMOTE_REFUSED] = 1'b1;
            end
            else if (q.waddr == iptu_pkg::OFF_TEST_CTRL)
            begin
                if (special_mode && q.wlane)
                    d.test_control_register = q.wbyte[4:0];
                else
                    ev[iptu_pkg::EV_TEST_REFUSED] = 1'b1;
            end
            else if (q.waddr == iptu_pkg::OFF_FORCED_TEST)
                ev[iptu_pkg::EV_TEST_REFUSED] = ~wr_test;
            else if (q.waddr == iptu_pkg::OFF_MASK)
            begin
                if (q.wlane)
                begin
                    d.mask = q.wbyte[iptu_pkg::EV_W-1:0];
                end
            end
            else if (q.waddr == iptu_pkg::OFF_STATUS)
            begin
                if (q.wlane)
                begin
                    d.status = q.status & ~q.wbyte[iptu_pkg::EV_W-1:0];
                end
            end
            else if (q.waddr != iptu_pkg::OFF_VECTOR)
            begin
                d.bresp = iptu_pkg::RESP_SLVERR;
            end
        end
        if (q.rvalid && rready)
        begin
            d.rvalid = 1'b0;
        end
        if (arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rdata = rd_word;
            d.rresp = rd_resp;
        end
        // Resets outrank the nonmaskable request, which outranks the rest
        d.vec_valid = 1'b1;
        // Promoted source alone leaves the picker empty, so test it first
        if (por_req)
            d.vec = iptu_pkg::VEC_POR;
        else if (clock_monitor_req)
            d.vec = iptu_pkg::VEC_CLKMON;
        else if (watchdog_supervisor_req)
            d.vec = iptu_pkg::VEC_WDOG;
        else if (eff[iptu_pkg::NONMASKABLE_EXTERNAL_REQUEST_IDX])
            d.vec = {iptu_pkg::VEC_PAGE, iptu_pkg::NONMASKABLE_EXTERNAL_REQUEST_IDX, 1'b0};
        else if (valid_m[p_idx])
            d.vec = {iptu_pkg::VEC_PAGE, p_idx, 1'b0};
        else if (pick_found)
            d.vec = {iptu_pkg::VEC_PAGE,
                pick_idx == p_idx ? iptu_pkg::RTI_IDX : pick_idx,
                1'b0};
        else
        begin
            d.vec_valid = 1'b0;
            d.vec = 16'h0000;
        end
        ev[iptu_pkg::EV_RESET_VECTOR] = por_req | clock_monitor_req
            | watchdog_supervisor_req;
        // A new event beats a clear in the same cycle
        d.status = d.status | ev;
        d.irq = |(d.status & d.mask);
        d.awready = ~d.aw_got & ~d.bvalid;
        d.wready = ~d.w_got & ~d.bvalid;
        d.arready = ~d.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.test_control_register <= iptu_pkg::TEST_CTRL_RESET;
            q.promote <= iptu_pkg::PROMOTE_RESET;
            q.status <= iptu_pkg::EV_RESET;
            q.mask <= iptu_pkg::EV_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign vector_valid = q.vec_valid;
    assign vector_address = q.vec;
    assign irq = q.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_promote_locked;
        do_write && q.waddr == iptu_pkg::OFF_PROMOTE && !cpu_int_mask
            |=> $stable(q.promote);
    endproperty
    a_promote_locked: assert property (p_promote_locked)
        else $error("promote register changed while unmasked");
    property p_promote_default;
        do_write && q.waddr == iptu_pkg::OFF_PROMOTE && cpu_int_mask
            && q.wlane && q.wbyte > 8'hF2 |=> q.promote == 8'hF2;
    endproperty
    a_promote_default: assert property (p_promote_default)
        else $error("out of range promote did not default");
    property p_test_locked;
        do_write && q.waddr == iptu_pkg::OFF_FORCED_TEST
            && (!special_mode || !test_we) |=> $stable(forced);
    endproperty
    a_test_locked: assert property (p_test_locked)
        else $error("forcing bits written without permission");
    property p_last_group;
        arvalid && arready && araddr == iptu_pkg::OFF_FORCED_TEST
            && sel == 4'hF |=> rvalid && rdata[7:3] == 5'h00;
    endproperty
    a_last_group: assert property (p_last_group)
        else $error("upper bits of last group not zero");
    property p_user_mode_zero;
        arvalid && arready && !special_mode
            && (araddr == iptu_pkg::OFF_FORCED_TEST
            || araddr == iptu_pkg::OFF_TEST_CTRL) |=> rdata == 32'h0;
    endproperty
    a_user_mode_zero: assert property (p_user_mode_zero)
        else $error("test register visible outside special mode");
    property p_por_vector;
        por_req |=> vector_valid && vector_address == 16'hFFFE;
    endproperty
    a_por_vector: assert property (p_por_vector)
        else $error("power-on vector not presented");
    property p_watchdog_vector;
        watchdog_supervisor_req && !por_req && !clock_monitor_req
            |=> vector_address == 16'hFFFA;
    endproperty
    a_watchdog_vector: assert property (p_watchdog_vector)
        else $error("watchdog vector not presented");
    property p_wake;
        low_power && nonmaskable_external_request |-> wakeup;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake-up on nonmaskable request");
    property p_force_only;
        force_active && !por_req && !clock_monitor_req
            && !watchdog_supervisor_req && forced == '0 |=> !vector_valid;
    endproperty
    a_force_only: assert property (p_force_only)
        else $error("external request leaked during forcing");

    property p_promoted_wins;
        !cpu_int_mask && !force_active && int_req[p_idx]
            && !nonmaskable_external_request && !por_req
            && !clock_monitor_req && !watchdog_supervisor_req
            |=> vector_address == {8'hFF, $past(p_idx), 1'b0};
    endproperty
    a_promoted_wins: assert property (p_promoted_wins)
        else $error("promoted request did not win");

    c_forced: cover property (grp_we != '0 ##1 vector_valid);
    c_promote: cover property (do_write
        && q.waddr == iptu_pkg::OFF_PROMOTE && cpu_int_mask);
    c_wake: cover property (wakeup);
    c_irq: cover property (irq);
endmodule : interrupt_priority_test_unit

// [interrupt_priority_test_unit_tb.sv]
// Self-checking bench of the interrupt priority and test unit
`timescale 1ns/1ps
module interrupt_priority_test_unit_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic special_mode = 1'b0;
    logic mask_request = 1'b1;
    logic cpu_int_mask;
    logic low_power = 1'b0;
    logic [iptu_pkg::REQ_W-1:0] int_req = '0;
    logic nmi = 1'b0;
    logic [2:0] rst_req = 3'h0;
    logic vector_valid;
    logic [15:0] vector_address;
    logic wakeup;
    logic irq;
    logic [15:0] last_vector;
    logic [1:0] last_resp;
    logic [31:0] last_data;
    int bad_count = 0;
    int samples_checked = 0;

    always #2.5 aclk = ~aclk;

    interrupt_priority_test_unit dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .special_mode(special_mode), .cpu_int_mask(cpu_int_mask),
        .low_power(low_power), .int_req(int_req),
        .nonmaskable_external_request(nmi), .por_req(rst_req[2]),
        .clock_monitor_req(rst_req[1]),
        .watchdog_supervisor_req(rst_req[0]),
        .vector_valid(vector_valid), .vector_address(vector_address),
        .wakeup(wakeup), .irq(irq)
    );

    cpu_core_model core_u (
        .aclk(aclk), .aresetn(aresetn), .mask_request(mask_request),
        .vector_valid(vector_valid), .vector_address(vector_address),
        .cpu_int_mask(cpu_int_mask), .last_vector(last_vector)
    );

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic guard(input int n);
        if (n >= 50)
        begin
            bad_count++;
            tally_and_finish();
        end
    endtask : guard

    // Trailing idle edge keeps bready from being set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (!bvalid && n < 50);
        last_resp = bresp;
        bready <= 1'b0;
        guard(n);
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!rvalid && n < 50);
        last_resp = rresp;
        last_data = rdata;
        rready <= 1'b0;
        guard(n);
        chk(last_data, exp);
        @(posedge aclk);
    endtask : rd

    task automatic vchk(input logic [15:0] exp);
        repeat (3) @(posedge aclk);
        chk({15'h0000, vector_valid, vector_address}, {16'h0001, exp});
    endtask : vchk

    task automatic set_mask(input logic m);
        mask_request <= m;
        repeat (2) @(posedge aclk);
    endtask : set_mask

    task automatic reset_values;
        rd(8'h7C, 32'h000000F2);
        chk({30'h0, last_resp}, 32'h00000000);
        rd(8'h40, 32'h00000000);
        rd(8'h60, 32'h00000000);
        chk({30'h0, last_resp}, 32'h00000002);
        wr(8'h60, 8'h00);
        chk({30'h0, last_resp}, 32'h00000002);
    endtask : reset_values

    task automatic refused_promote_irq;
        set_mask(1'b0);
        wr(8'h7C, 8'h20);
        rd(8'h7C, 32'h000000F2);
        rd(8'h40, 32'h00000001);
        chk({31'h0, irq}, 32'h00000000);
        wr(8'h44, 8'h01);
        chk({31'h0, irq}, 32'h00000001);
        wr(8'h40, 8'h01);
        chk({31'h0, irq}, 32'h00000000);
    endtask : refused_promote_irq

    task automatic promotion;
        set_mask(1'b1);
        wr(8'h7C, 8'hF8);
        rd(8'h7C, 32'h000000F2);
        wr(8'h7C, 8'h20);
        rd(8'h7C, 32'h00000020);
        set_mask(1'b0);
        int_req <= '0;
        int_req[8'h10] <= 1'b1;
        int_req[8'h50] <= 1'b1;
        vchk(16'hFF20);
        int_req[8'h50] <= 1'b0;
        vchk(16'hFF20);
        int_req[8'h50] <= 1'b1;
        int_req[8'h10] <= 1'b0;
        int_req[8'h78] <= 1'b1;
        vchk(16'hFFA0);
        set_mask(1'b1);
        wr(8'h7C, 8'hF2);
        set_mask(1'b0);
        int_req[8'h78] <= 1'b0;
        int_req[8'h10] <= 1'b1;
        vchk(16'hFFA0);
        int_req[8'h79] <= 1'b1;
        vchk(16'hFFF2);
        int_req <= '0;
    endtask : promotion

    task automatic reset_vectors;
        logic [15:0] exp [4];
        exp = '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF4};
        int_req[8'h50] <= 1'b1;
        nmi <= 1'b1;
        rst_req <= 3'h7;
        for (int i = 0; i < 4; i++)
        begin
            vchk(exp[i]);
            rst_req <= rst_req >> 1;
        end
        chk({16'h0000, last_vector}, 32'h0000FFF4);
        nmi <= 1'b0;
        int_req <= '0;
        wr(8'h40, 8'h07);
        rd(8'h40, 32'h00000000);
    endtask : reset_vectors

    task automatic test_registers;
        wr(8'h1C, 8'h12);
        rd(8'h1C, 32'h00000000);
        special_mode <= 1'b1;
        set_mask(1'b1);
        wr(8'h1C, 8'h12);
        rd(8'h1C, 32'h00000012);
        wr(8'h20, 8'h81);
        int_req[8'h50] <= 1'b1;
        nmi <= 1'b1;
        vchk(16'hFF2E);
        chk({31'h0, vector_valid}, 32'h00000001);
        rd(8'h20, 32'h00000081);
        wr(8'h1C, 8'h1F);
        wr(8'h20, 8'hFF);
        rd(8'h20, 32'h00000007);
        nmi <= 1'b0;
        int_req <= '0;
        int_req[8'h12] <= 1'b1;
        wr(8'h1C, 8'h02);
        wr(8'h20, 8'h01);
        rd(8'h40, 32'h00000002);
        rd(8'h20, 32'h00000004);
        wr(8'h40, 8'h02);
        wr(8'h1C, 8'h00);
        special_mode <= 1'b0;
        int_req <= '0;
    endtask : test_registers

    task automatic wake_path;
        set_mask(1'b0);
        low_power <= 1'b1;
        @(posedge aclk);
        #1 chk({31'h0, wakeup}, 32'h00000000);
        int_req[8'h30] <= 1'b1;
        @(posedge aclk);
        #1 chk({31'h0, wakeup}, 32'h00000001);
        int_req <= '0;
        nmi <= 1'b1;
        @(posedge aclk);
        #1 chk({31'h0, wakeup}, 32'h00000001);
        nmi <= 1'b0;
        low_power <= 1'b0;
        @(posedge aclk);
    endtask : wake_path

    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        reset_values();
        refused_promote_irq();
        promotion();
        reset_vectors();
        test_registers();
        wake_path();
        tally_and_finish();
    end
endmodule : interrupt_priority_test_unit_tb

// [iptu_pkg.sv]
// Constants, offsets and layouts of the interrupt priority and test unit
// Operation
// - Each test bit forces one vector
// - Test writes need special mode and enable
// - Forcing disconnects external request inputs from the decoder; wake-up still sees the nonmaskable pin
// - Test register reads show arrived requests
// - One test register per eight interrupts
// - Last group exposes only bits two to zero
// - Unimplemented group ignores writes, reads zero
// - Promote register writes need interrupt mask
// - Written vector byte promotes that interrupt
// - Out-of-range value defaults to external request
// - Tick interrupt takes promoted source's place
// - Decoder validates and ranks pending requests
// - Asynchronous wake-up on valid or nonmaskable
// - Three reset types give own vectors
// - Test registers reachable only in special mode
package iptu_pkg;
    localparam int NUM_GROUPS = 16;
    localparam int GRP_W = 4;
    localparam int IDX_W = 7;
    localparam int REQ_W = 128;
    localparam int MASKABLE_W = 122;
    localparam int EV_W = 3;
    // Byte addresses on the register bus
    localparam logic [7:0] OFF_TEST_CTRL = 8'h1C;
    localparam logic [7:0] OFF_FORCED_TEST = 8'h20;
    localparam logic [7:0] PROMOTE_IDX = 8'h1F;
    localparam logic [7:0] OFF_PROMOTE = {PROMOTE_IDX[5:0], 2'b00};
    localparam logic [7:0] OFF_STATUS = 8'h40;
    localparam logic [7:0] OFF_MASK = 8'h44;
    localparam logic [7:0] OFF_VECTOR = 8'h48;
    // Test control layout
    localparam int TC_WE_BIT = 4;
    localparam logic [4:0] TEST_CTRL_RESET = 5'h00;
    // Promotion
    localparam logic [7:0] PROMOTE_RESET = 8'hF2;
    localparam logic [7:0] PROMOTE_LIMIT = 8'hF2;
    localparam logic [6:0] IRQ_IDX = 7'h79;
    localparam logic [6:0] NONMASKABLE_EXTERNAL_REQUEST_IDX = 7'h7A;
    localparam logic [6:0] RTI_IDX = 7'h78;
    localparam logic [3:0] LAST_GROUP = 4'hF;
    localparam logic [7:0] LAST_GROUP_MASK = 8'h07;
    localparam logic [7:0] FULL_GROUP_MASK = 8'hFF;
    // Vectors
    localparam logic [7:0] VEC_PAGE = 8'hFF;
    localparam logic [15:0] VEC_POR = 16'hFFFE;
    localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
    localparam logic [15:0] VEC_WDOG = 16'hFFFA;
    // Event bits of status and mask
    localparam int EV_PROMOTE_REFUSED = 0;
    localparam int EV_TEST_REFUSED = 1;
    localparam int EV_RESET_VECTOR = 2;
    localparam logic [2:0] EV_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : iptu_pkg

// [priority_pick.sv]
// Fixed priority picker: highest set index wins
`timescale 1ns/1ps
module priority_pick #(
    parameter int WIDTH = 122,
    parameter int IDX_W = 7
) (
    // Requests
    input wire logic [WIDTH-1:0] req,
    // Result
    output logic found,
    output logic [IDX_W-1:0] index
);
    always_comb
    begin
        found = 1'b0;
        index = '0;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (req[i])
            begin
                found = 1'b1;
                index = IDX_W'(i);
            end
        end
    end
endmodule : priority_pick
